// ===== rtl/becc_pkg.sv
/*
   package for the bearer error element codec: element identifiers, cause and reason
   codes, element octet counts, request and octet-stream carriers.
   assumes an octet stream sink with valid/ready handshake on the same clock.
*/
`default_nettype none
package becc_pkg;

   localparam logic [7:0] BECC_ID_PROTO_ERR = 8'h45;
   localparam logic [7:0] BECC_ID_CONN_INC  = 8'h46;
   localparam logic [7:0] BECC_EXT_BIT      = 8'h80;
   localparam int         BECC_EXT_POS      = 7;

   // content length = total size minus identifier and length octets
   localparam logic [2:0] BECC_HDR_OCTETS   = 3'h2;
   localparam logic [2:0] BECC_MIN_TOTAL    = 3'h3;
   localparam logic [2:0] BECC_MAX_TOTAL    = 3'h5;

   typedef enum logic [6:0] {
      BECC_CAUSE_DISCRIM     = 7'h01,
      BECC_CAUSE_MSG_UNKNOWN = 7'h04,
      BECC_CAUSE_OUT_OF_SEQ  = 7'h05,
      BECC_CAUSE_REP_OPT     = 7'h06,
      BECC_CAUSE_MAND_MISS   = 7'h07,
      BECC_CAUSE_ELEM_UNKN   = 7'h08,
      BECC_CAUSE_MAND_CONT   = 7'h09,
      BECC_CAUSE_OPT_CONT    = 7'h0a,
      BECC_CAUSE_STATE_INCMP = 7'h0b,
      BECC_CAUSE_REP_MAND    = 7'h0c,
      BECC_CAUSE_TOO_MANY    = 7'h0d,
      BECC_CAUSE_REF_CODING  = 7'h0f
   } becc_cause_e;

   typedef enum logic [6:0] {
      BECC_RSN_NORMAL        = 7'h00,
      BECC_RSN_AN_FAULT      = 7'h01,
      BECC_RSN_PORT_UNPROV   = 7'h02,
      BECC_RSN_BAD_SLOT      = 7'h03,
      BECC_RSN_BAD_LINK      = 7'h04,
      BECC_RSN_SLOT_IS_CCH   = 7'h05
   } becc_reason_e;

   typedef enum logic [1:0] {
      BECC_KIND_PROTO_ERR = 2'b01,
      BECC_KIND_CONN_INC  = 2'b10
   } becc_kind_e;

   typedef struct packed {
      becc_kind_e  kind;
      logic [6:0]  code;
      logic [7:0]  msg_type;
      logic [7:0]  elem_id;
   } becc_req_s;

   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } becc_octet_s;

endpackage
`default_nettype wire

// ===== rtl/becc_diag_len.sv
/*
   maps a protocol error cause to its diagnostic length and validity.
   assumes a purely combinational use by the framer.
*/
`default_nettype none
module becc_diag_len
   import becc_pkg::*;
(
   input  wire logic [6:0] cause,
   output logic [1:0]      diag_len,
   output logic            known
);
   import becc_pkg::*;

   always_comb begin
      known    = 1'b1;
      case (cause)
         BECC_CAUSE_DISCRIM,
         BECC_CAUSE_REF_CODING:  diag_len = 2'h0;
         BECC_CAUSE_MSG_UNKNOWN,
         BECC_CAUSE_STATE_INCMP,
         BECC_CAUSE_TOO_MANY:    diag_len = 2'h1;
         BECC_CAUSE_OUT_OF_SEQ,
         BECC_CAUSE_REP_OPT,
         BECC_CAUSE_MAND_MISS,
         BECC_CAUSE_ELEM_UNKN,
         BECC_CAUSE_MAND_CONT,
         BECC_CAUSE_OPT_CONT,
         BECC_CAUSE_REP_MAND:    diag_len = 2'h2;
         default: begin
            diag_len = 2'h0;
            known    = 1'b0;
         end
      endcase
   end
endmodule
`default_nettype wire

// ===== rtl/becc_reason_chk.sv
/*
   checks a connection incomplete reason code against the defined set.
   assumes a purely combinational use by the framer.
*/
`default_nettype none
module becc_reason_chk
   import becc_pkg::*;
(
   input  wire logic [6:0] reason,
   output logic            known
);
   import becc_pkg::*;

   always_comb begin
      case (reason)
         BECC_RSN_NORMAL, BECC_RSN_AN_FAULT, BECC_RSN_PORT_UNPROV,
         BECC_RSN_BAD_SLOT, BECC_RSN_BAD_LINK, BECC_RSN_SLOT_IS_CCH: known = 1'b1;
         default: known = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ===== rtl/becc_framer.sv
/*
   bearer error element codec: builds protocol error and connection incomplete
   elements as an octet stream, one octet per accepted beat.
   assumes requests and the stream sink run on CORE_CLK; sink may stall.
*/
// What this block does
// - access network reports detected protocol error type via protocol error element.
// - diagnostic copies offending message type bits 7:1 with bit 8 cleared, then element identifier when needed.
// - protocol error element totals between three and five octets.
// - causes without diagnostic give exactly three octets.
// - causes with diagnostic give four or five octets.
// - octets: identifier 45h, length, ext plus cause, message type, element id.
// - cause codes 1,4-13,15 defined; others reserved.
// - diagnostic length zero, one or two octets by cause.
// - connection incomplete element reports failed audit without connection.
// - connection incomplete element is exactly three octets.
// - octets: identifier 46h, length, ext flag plus seven-bit reason.
// - reason codes 0 to 5 defined; others reserved.
`default_nettype none
module becc_framer
   import becc_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        RESET_N,
   input  wire logic        REQ_VALID,
   output logic             REQ_READY,
   input  wire becc_pkg::becc_req_s REQ,
   output logic             REQ_REJECT,
   output logic             OUT_VALID,
   input  wire logic        OUT_READY,
   output becc_pkg::becc_octet_s OUT_OCTET,
   output logic             BUSY
);
   import becc_pkg::*;

   typedef enum logic [1:0] {
      BECC_ST_IDLE = 2'b00,
      BECC_ST_SEND = 2'b01
   } becc_state_e;

   becc_state_e       state_ff;
   becc_state_e       nxt_state;
   logic [7:0]        octets_ff [0:4];
   logic [2:0]        total_ff;
   logic [2:0]        idx_ff;
   logic [2:0]        nxt_idx;
   logic              reject_ff;

   logic [1:0]        diag_len;
   logic              cause_known;
   logic              reason_known;
   logic              is_perr;
   logic              is_cinc;
   logic              req_ok;
   logic [2:0]        req_total;
   logic              fire_req;
   logic              fire_out;

   becc_diag_len u_diag_len (
      .cause    (REQ.code),
      .diag_len (diag_len),
      .known    (cause_known)
   );

   becc_reason_chk u_reason_chk (
      .reason (REQ.code),
      .known  (reason_known)
   );

   function automatic logic [7:0] ext_octet(input logic [6:0] code);
      ext_octet = BECC_EXT_BIT | {1'b0, code};
   endfunction

   assign is_perr = (REQ.kind == BECC_KIND_PROTO_ERR);
   assign is_cinc = (REQ.kind == BECC_KIND_CONN_INC);

   assign req_ok = (is_perr && cause_known) || (is_cinc && reason_known);

   assign req_total = is_perr ? BECC_MIN_TOTAL + {1'b0, diag_len} : BECC_MIN_TOTAL;

   assign REQ_READY = (state_ff == BECC_ST_IDLE);
   assign fire_req  = REQ_VALID && REQ_READY;
   assign fire_out  = OUT_VALID && OUT_READY;
   assign OUT_VALID = (state_ff == BECC_ST_SEND);
   assign BUSY      = (state_ff == BECC_ST_SEND);
   assign REQ_REJECT = reject_ff;

   always_comb begin
      OUT_OCTET.data = octets_ff[idx_ff];
      OUT_OCTET.last = (idx_ff == total_ff - 3'h1);
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_idx   = idx_ff;
      case (state_ff)
         BECC_ST_IDLE: begin
            nxt_idx = 3'h0;
            if (fire_req && req_ok) begin
               nxt_state = BECC_ST_SEND;
            end
         end
         BECC_ST_SEND: begin
            if (fire_out) begin
               if (OUT_OCTET.last) begin
                  nxt_state = BECC_ST_IDLE;
                  nxt_idx   = 3'h0;
               end else begin
                  nxt_idx = idx_ff + 3'h1;
               end
            end
         end
         default: begin
            nxt_state = BECC_ST_IDLE;
            nxt_idx   = 3'h0;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         state_ff <= BECC_ST_IDLE;
         idx_ff   <= 3'h0;
      end else begin
         state_ff <= nxt_state;
         idx_ff   <= nxt_idx;
      end
   end

   // one-cycle pulse for refused request
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         reject_ff <= 1'b0;
      end else begin
         reject_ff <= fire_req && !req_ok;
      end
   end

   // element image captured at acceptance
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         total_ff <= BECC_MIN_TOTAL;
         for (int i = 0; i < 5; i++) begin
            octets_ff[i] <= 8'h00;
         end
      end else if (fire_req && req_ok) begin
         total_ff <= req_total;
         octets_ff[0] <= is_perr ? BECC_ID_PROTO_ERR : BECC_ID_CONN_INC;
         octets_ff[1] <= {5'h00, req_total - BECC_HDR_OCTETS};
         octets_ff[2] <= ext_octet(REQ.code);
         octets_ff[3] <= {1'b0, REQ.msg_type[6:0]};
         octets_ff[4] <= REQ.elem_id;
      end
   end

endmodule
`default_nettype wire

// ===== testbench/becc_framer_sva.sv
/*
   port checker for the bearer error element codec framer.
   assumes becc_pkg is compiled first; bound into becc_framer below.
*/
`default_nettype none
module becc_framer_chk
   import becc_pkg::*;
(
   input wire logic                  CORE_CLK,
   input wire logic                  RESET_N,
   input wire logic                  REQ_VALID,
   input wire logic                  REQ_READY,
   input wire becc_pkg::becc_req_s   REQ,
   input wire logic                  REQ_REJECT,
   input wire logic                  OUT_VALID,
   input wire logic                  OUT_READY,
   input wire becc_pkg::becc_octet_s OUT_OCTET,
   input wire logic                  BUSY
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt_ff;
   logic [7:0] id_ff;
   logic [7:0] len_ff;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   // octet index within element
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N)
         cnt_ff <= 3'h0;
      else if (OUT_VALID && OUT_READY)
         cnt_ff <= OUT_OCTET.last ? 3'h0 : cnt_ff + 3'h1;
   end
   always_ff @(posedge CORE_CLK) begin
      if (OUT_VALID && cnt_ff == 3'h0)
         id_ff <= OUT_OCTET.data;
      if (OUT_VALID && cnt_ff == 3'h1)
         len_ff <= OUT_OCTET.data;
   end
   sequence take_s; REQ_VALID && REQ_READY; endsequence
   sequence pe_s; take_s ##0 REQ.kind == BECC_KIND_PROTO_ERR; endsequence
   sequence ci_s; take_s ##0 REQ.kind == BECC_KIND_CONN_INC; endsequence
   pe_id_a: assert property (pe_s ##0 REQ.code inside {1, [4:13], 15}
      |=> OUT_VALID && OUT_OCTET.data == BECC_ID_PROTO_ERR) else $error("bad pe id");
   ci_id_a: assert property (ci_s ##0 REQ.code <= 7'h05
      |=> OUT_VALID && OUT_OCTET.data == BECC_ID_CONN_INC) else $error("bad ci id");
   pe_rsv_a: assert property (pe_s ##0 !(REQ.code inside {1, [4:13], 15})
      |=> REQ_REJECT && !OUT_VALID) else $error("pe code taken");
   ci_rsv_a: assert property (ci_s ##0 REQ.code > 7'h05
      |=> REQ_REJECT && !OUT_VALID) else $error("ci code taken");
   ext_bit_a: assert property (OUT_VALID && cnt_ff == 3'h2
      |-> OUT_OCTET.data[7]) else $error("ext bit clear");
   diag_msb_a: assert property (OUT_VALID && cnt_ff == 3'h3
      |-> !OUT_OCTET.data[7]) else $error("diag bit 8 set");
   ci_len_a: assert property (OUT_VALID && cnt_ff == 3'h1 && id_ff == 8'h46
      |-> OUT_OCTET.data == 8'h01) else $error("ci length");
   pe_len_a: assert property (OUT_VALID && cnt_ff == 3'h1 && id_ff == 8'h45
      |-> OUT_OCTET.data inside {[1:3]}) else $error("pe length");
   total_len_a: assert property (OUT_VALID && OUT_OCTET.last
      |-> cnt_ff == len_ff[2:0] + 3'h1) else $error("octet count");
   hold_out_a: assert property (OUT_VALID && !OUT_READY
      |=> OUT_VALID && $stable(OUT_OCTET)) else $error("octet moved");
   rej_pulse_a: assert property (REQ_REJECT && !REQ_VALID |=> !REQ_REJECT
      ##0 !BUSY) else $error("reject long");
endmodule
bind becc_framer becc_framer_chk u_chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
   .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ), .REQ_REJECT(REQ_REJECT),
   .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_OCTET(OUT_OCTET), .BUSY(BUSY));
`default_nettype wire

// ===== testbench/becc_sink.sv
/*
   octet sink standing in for the exchange side; may stall every other cycle.
   assumes one clock shared with the framer.
*/
`default_nettype none
module becc_sink
   import becc_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  slow,
   input  wire logic                  valid,
   input  wire becc_pkg::becc_octet_s octet,
   output logic                       ready,
   output logic                       len_err
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] q[$];
   logic       tick_ff = 1'b0;
   logic [1:0] want;
   assign ready = !slow || tick_ff;
   always @(posedge clk) begin
      tick_ff <= rst_n && !tick_ff;
      if (!rst_n)
         len_err <= 1'b0;
      if (rst_n && valid && ready) begin
         q.push_back(octet.data);
         if (octet.last) begin
            want = q[2][6:0] inside {1, 15} ? 2'h0 : q[2][6:0] inside {4, 11, 13} ? 2'h1 : 2'h2;
            len_err <= (q[1] + 8'h02 != 8'(q.size()))
                       || (q[0] == BECC_ID_PROTO_ERR && q[1] != 8'(want) + 8'h01);
         end
      end
   end
endmodule
`default_nettype wire

// ===== testbench/becc_framer_test.sv
/*
   self-checking bench for the bearer error element codec framer.
   assumes package, framer, sink and checker are compiled before it.
*/
`default_nettype none
module becc_framer_test;
   timeunit 1ns;
   timeprecision 1ps;
   import becc_pkg::*;
   logic        core_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        req_valid = 1'b0;
   logic        slow = 1'b0;
   becc_req_s   req = '0;
   logic        req_ready, req_reject, out_valid, out_ready, busy, len_err, rej;
   becc_octet_s out_octet;
   logic [7:0]  e[$];
   logic [6:0]  cs[12] = '{7'h01, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0a,
                          7'h0b, 7'h0c, 7'h0d, 7'h0f};
   int          err_count = 0;
   int          n_checks = 0;
   int          cycles = 0;
   int          d;
   always #10 core_clk = ~core_clk;
   becc_framer u_becc_framer (.CORE_CLK(core_clk), .RESET_N(reset_n), .REQ_VALID(req_valid),
      .REQ_READY(req_ready), .REQ(req), .REQ_REJECT(req_reject), .OUT_VALID(out_valid),
      .OUT_READY(out_ready), .OUT_OCTET(out_octet), .BUSY(busy));
   becc_sink u_becc_sink (.clk(core_clk), .rst_n(reset_n), .slow(slow), .valid(out_valid),
      .octet(out_octet), .ready(out_ready), .len_err(len_err));
   task check(input string name, input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task test_done;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         test_done;
      end
   end
   task send(input becc_kind_e k, input logic [6:0] c);
      @(posedge core_clk) #1;
      u_becc_sink.q.delete();
      req_valid = 1'b1;
      req = '{k, c, 8'hd5, 8'h3c};
      @(posedge core_clk) #1;
      req_valid = 1'b0;
      rej = req_reject;
      check("busy", {7'h00, busy}, {7'h00, !rej});
      for (int i = 0; i < 40 && !req_ready; i++)
         @(posedge core_clk) #1;
   endtask
   task cmp;
      check("reject", {7'h00, rej}, 8'h00);
      check("count", 8'(u_becc_sink.q.size()), 8'(e.size()));
      foreach (e[i])
         check("octet", u_becc_sink.q[i], e[i]);
      check("len_err", {7'h00, len_err}, 8'h00);
   endtask
   task t_causes;
      foreach (cs[i]) begin
         slow = i[0];
         send(BECC_KIND_PROTO_ERR, cs[i]);
         d = cs[i] inside {1, 15} ? 0 : cs[i] inside {4, 11, 13} ? 1 : 2;
         e = '{8'h45, 8'(d + 1), {1'b1, cs[i]}, 8'h55, 8'h3c};
         repeat (2 - d) void'(e.pop_back());
         cmp();
      end
   endtask
   task t_reasons;
      for (int r = 0; r < 6; r++) begin
         slow = r[0];
         send(BECC_KIND_CONN_INC, 7'(r));
         e = '{8'h46, 8'h01, {1'b1, 7'(r)}};
         cmp();
      end
   endtask
   task t_reserved;
      logic [8:0] bad[10] = '{9'h080, 9'h082, 9'h083, 9'h08e, 9'h090, 9'h0ff, 9'h106, 9'h17f,
                              9'h001, 9'h184};
      foreach (bad[i]) begin
         send(becc_kind_e'(bad[i][8:7]), bad[i][6:0]);
         check("refused", {7'h00, rej}, 8'h01);
         check("emitted", 8'(u_becc_sink.q.size()), 8'h00);
      end
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      #1;
      reset_n = 1'b1;
      check("ready", {7'h00, req_ready}, 8'h01);
      t_causes();
      t_reserved();
      t_reasons();
      test_done();
   end
endmodule
`default_nettype wire
